// >>> charge_pump_current_config.sv
// charge-pump current configuration register bank
`timescale 1ns/100ps
`default_nettype none
// Function
// - external source code bits 11-7, reset 10h
// - external gain bits 6-5, four multipliers
// - internal sink code bits 4-0, reset 10h
// - internal source code bits 12-8, reset 10h
// - internal gain bits 7-6, four multipliers
// - loop current equals gain times base
// - reset values 810h and 101Ch
// - external sink code at 2Ah bits 4-0
module charge_pump_current_config
  import pump_current_pkg::*;
(
  input  wire logic                 core_clk,    // 25 MHz clock
  input  wire logic                 rstn,        // async reset, active low
  input  wire logic [AddrWidth-1:0] regAddr,     // register address
  input  wire logic [DataWidth-1:0] regWrData,   // write data
  input  wire logic                 regWrite,    // write strobe
  input  wire logic                 regRead,     // read strobe
  output logic      [DataWidth-1:0] regRdData,   // read data, cycle after strobe
  input  wire logic                 extOscMode,  // 1: external oscillator loop
  output pump_cfg_type              pumpCfg,     // selected codes and gain
  output logic      [CurWidth-1:0]  pumpCurrent  // loop current, 1/4 uA per lsb, 16-bit wrap
);

  // =====================================================================
  // registers
  logic [DataWidth-1:0] intPump_q, intPump_d;
  logic [DataWidth-1:0] extPump_q, extPump_d;
  logic [DataWidth-1:0] extSink_q, extSink_d;
  logic [DataWidth-1:0] rdData_q, rdData_d;
  pump_cfg_type         cfg_q, cfg_d;
  logic [CurWidth-1:0]  cur_q, cur_d;

  // field views
  logic [CodeWidth-1:0] extSourceCode;
  logic [CodeWidth-1:0] extSinkCode;
  logic [CodeWidth-1:0] intSourceCode;
  logic [CodeWidth-1:0] intSinkCode;
  gain_type             extGain;
  gain_type             intGain;

  // field extraction
  assign extSourceCode = extPump_q[ExtSourceLsb +: CodeWidth];
  assign extGain       = gain_type'(extPump_q[ExtGainLsb +: GainWidth]);
  assign intSinkCode   = extPump_q[IntSinkLsb +: CodeWidth];
  assign intSourceCode = intPump_q[IntSourceLsb +: CodeWidth];
  assign intGain       = gain_type'(intPump_q[IntGainLsb +: GainWidth]);
  assign extSinkCode   = extSink_q[ExtSinkLsb +: CodeWidth];

  // =====================================================================
  // register writes; full word stored, reserved bits are software's duty
  always_comb begin
    intPump_d = intPump_q;
    extPump_d = extPump_q;
    extSink_d = extSink_q;
    if (regWrite) begin
      case (regAddr)
        IntPumpOffset: intPump_d = regWrData;
        ExtPumpOffset: extPump_d = regWrData;
        ExtSinkOffset: extSink_d = regWrData;
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdData_d = '0;
    if (regRead) begin
      case (regAddr)
        IntPumpOffset: rdData_d = intPump_q;
        ExtPumpOffset: rdData_d = extPump_q;
        ExtSinkOffset: rdData_d = extSink_q;
        default:       rdData_d = '0;
      endcase
    end
  end

  // =====================================================================
  // pump current: base = (source+sink) * step, times gain
  function automatic logic [CurWidth-1:0] scaled(input logic [CodeWidth-1:0] a,
                                                  input logic [CodeWidth-1:0] b,
                                                  input gain_type g);
    logic [CurWidth-1:0] base;
    logic [CurWidth-1:0] half;
    base = CurWidth'({1'b0, a} + {1'b0, b}) * StepQuarter;
    half = base >> 1;
    case (g)
      GAIN_1X:  scaled = base;
      GAIN_2X:  scaled = base << 1;
      GAIN_1P5: scaled = base + half;
      GAIN_2P5: scaled = (base << 1) + half;
      default:  scaled = base;
    endcase
  endfunction

  // select the active configuration by oscillator mode
  always_comb begin
    if (extOscMode) begin
      cfg_d = '{sourceCode: extSourceCode, sinkCode: extSinkCode, gain: extGain};
      cur_d = scaled(extSourceCode, extSinkCode, extGain);
    end else begin
      cfg_d = '{sourceCode: intSourceCode, sinkCode: intSinkCode, gain: intGain};
      cur_d = scaled(intSourceCode, intSinkCode, intGain);
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      intPump_q <= IntPumpReset;
      extPump_q <= ExtPumpReset;
      extSink_q <= ExtSinkReset;
      rdData_q  <= '0;
      cfg_q     <= '0;
      cur_q     <= '0;
    end else begin
      intPump_q <= intPump_d;
      extPump_q <= extPump_d;
      extSink_q <= extSink_d;
      rdData_q  <= rdData_d;
      cfg_q     <= cfg_d;
      cur_q     <= cur_d;
    end
  end

  assign regRdData   = rdData_q;
  assign pumpCfg     = cfg_q;
  assign pumpCurrent = cur_q;

  // =====================================================================
  // checks
  extWrite_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == ExtPumpOffset |=> extPump_q == $past(regWrData))
    else $error("external pump register not updated");
  readBack_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == IntPumpOffset && !$past(regWrite) |=> regRdData == $past(intPump_q))
    else $error("internal pump readback mismatch");
  intSrc_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !extOscMode ##1 1 |-> pumpCfg.sourceCode == $past(intPump_q[IntSourceLsb +: CodeWidth]))
    else $error("internal source code not applied");
  extSinkSel_a: assert property (@(posedge core_clk) disable iff (!rstn)
    extOscMode |=> pumpCfg.sinkCode == $past(extSink_q[ExtSinkLsb +: CodeWidth]))
    else $error("external sink code not applied");
  intSink_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !extOscMode |=> pumpCfg.sinkCode == $past(extPump_q[IntSinkLsb +: CodeWidth]))
    else $error("internal sink code not applied");
  gainDouble_a: assert property (@(posedge core_clk) disable iff (!rstn)
    extOscMode && extGain == GAIN_2X |=> pumpCurrent ==
      CurWidth'(({1'b0, $past(extSourceCode)} + {1'b0, $past(extSinkCode)}) * StepQuarter * 2))
    else $error("external 2x gain wrong");
  gainOne_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !extOscMode && intGain == GAIN_1X |=> pumpCurrent ==
      CurWidth'(({1'b0, $past(intSourceCode)} + {1'b0, $past(intSinkCode)}) * StepQuarter))
    else $error("internal 1x gain wrong");
  triState_a: assert property (@(posedge core_clk) disable iff (!rstn)
    extOscMode && extSourceCode == '0 && extSinkCode == '0 |=> pumpCurrent == '0)
    else $error("zero codes must give no current");

  // =====================================================================
  // usage notes
  // the bank stores every written bit, reserved ones included; keeping
  // the fixed patterns in the reserved fields is left to software, so a
  // careless write shows up on readback rather than being silently fixed.
  // source and sink codes are applied as written: odd or unequal codes in
  // the external pair are not refused here, the analog side sees them.
  // the loop current output is a 16-bit value in quarter-microamps; the
  // largest codes with the larger gains wrap, so it is an estimate for
  // monitoring and not a precise current.
  // the half-step gains use the base current halved and rounded down,
  // which matches the loose accuracy of the multipliers themselves.
  // the active configuration follows the mode pin one edge later and a
  // register write two edges after the write strobe.
  // reads never stall: data stands one cycle after the read strobe and
  // the read port returns zero in every other cycle.

  // =====================================================================
  // register write checks
  // internal register takes the written word
  intWrite_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == IntPumpOffset
    |=> intPump_q == $past(regWrData))
    else $error("internal pump register not updated");

  // external sink register takes the written word
  sinkWrite_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regWrite && regAddr == ExtSinkOffset
    |=> extSink_q == $past(regWrData))
    else $error("external sink register not updated");

  // internal register holds without a write to it
  intHold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && regAddr == IntPumpOffset)
    |=> intPump_q == $past(intPump_q))
    else $error("internal pump register changed without write");

  // external register holds without a write to it
  extHold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && regAddr == ExtPumpOffset)
    |=> extPump_q == $past(extPump_q))
    else $error("external pump register changed without write");

  // sink register holds without a write to it
  sinkHold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(regWrite && regAddr == ExtSinkOffset)
    |=> extSink_q == $past(extSink_q))
    else $error("external sink register changed without write");

  // =====================================================================
  // read port checks
  // external register reads back its contents
  extRead_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == ExtPumpOffset
    |=> regRdData == $past(extPump_q))
    else $error("external pump readback mismatch");

  // sink register reads back its contents
  sinkRead_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr == ExtSinkOffset
    |=> regRdData == $past(extSink_q))
    else $error("external sink readback mismatch");

  // unmapped addresses read as zero
  unmappedRead_a: assert property (@(posedge core_clk) disable iff (!rstn)
    regRead && regAddr != IntPumpOffset && regAddr != ExtPumpOffset && regAddr != ExtSinkOffset
    |=> regRdData == '0)
    else $error("unmapped read not zero");

  // read data stands only after a read strobe
  idleRead_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !regRead
    |=> regRdData == '0)
    else $error("read data outside read cycle");

  // =====================================================================
  // field application checks
  // external source code reaches the pump
  extSrc_a: assert property (@(posedge core_clk) disable iff (!rstn)
    extOscMode
    |=> pumpCfg.sourceCode == $past(extPump_q[ExtSourceLsb +: CodeWidth]))
    else $error("external source code not applied");

  // external gain field reaches the pump
  extGain_a: assert property (@(posedge core_clk) disable iff (!rstn)
    extOscMode
    |=> pumpCfg.gain == $past(extPump_q[ExtGainLsb +: GainWidth]))
    else $error("external gain not applied");

  // internal gain field reaches the pump
  intGain_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !extOscMode
    |=> pumpCfg.gain == $past(intPump_q[IntGainLsb +: GainWidth]))
    else $error("internal gain not applied");

  // =====================================================================
  // loop current checks
  // internal one-and-a-half gain on the summed base
  gainHalf_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !extOscMode && intGain == GAIN_1P5 |=> pumpCurrent ==
      CurWidth'((({1'b0, $past(intSourceCode)} + {1'b0, $past(intSinkCode)}) * StepQuarter) * 3 / 2))
    else $error("internal 1.5x gain wrong");

  // external two-and-a-half gain on the summed base
  gainTwoHalf_a: assert property (@(posedge core_clk) disable iff (!rstn)
    extOscMode && extGain == GAIN_2P5 |=> pumpCurrent ==
      CurWidth'((({1'b0, $past(extSourceCode)} + {1'b0, $past(extSinkCode)}) * StepQuarter) * 5 / 2))
    else $error("external 2.5x gain wrong");

endmodule
`default_nettype wire

// >>> charge_pump_current_config_test.sv
// self-checking testbench for the charge-pump current register bank
`timescale 1ns/100ps
`default_nettype none
module charge_pump_current_config_test;
  import pump_current_pkg::*;
  // ==========================================================
  // signals and table
  typedef struct {logic [15:0] r28, r29, r2a; logic mode; logic [4:0] src, snk; logic [1:0] g;} row_type;
  logic                 core_clk = 1'b0;
  logic                 rstn = 1'b0;
  logic [AddrWidth-1:0] regAddr = 8'h00;
  logic [DataWidth-1:0] regWrData = 16'h0000;
  logic                 regWrite = 1'b0;
  logic                 regRead = 1'b0;
  logic                 extOscMode = 1'b0;
  logic [DataWidth-1:0] regRdData;
  pump_cfg_type         pumpCfg;
  logic [CurWidth-1:0]  pumpCurrent;
  int                   miscompares = 0;
  int                   total_checks = 0;
  row_type rows [8] = '{
    '{16'h021C, 16'h0222, 16'h0204, 1'b0, 5'h02, 5'h02, 2'h0},
    '{16'h021C, 16'h0222, 16'h0204, 1'b1, 5'h04, 5'h04, 2'h1},
    '{16'h1FDC, 16'h0F5F, 16'h021E, 1'b0, 5'h1F, 5'h1F, 2'h3},
    '{16'h1FDC, 16'h0F5F, 16'h021E, 1'b1, 5'h1E, 5'h1E, 2'h2},
    '{16'h019C, 16'h0061, 16'h0200, 1'b0, 5'h01, 5'h01, 2'h2},
    '{16'h019C, 16'h0061, 16'h0200, 1'b1, 5'h00, 5'h00, 2'h3},
    '{16'h105C, 16'h0810, 16'h0210, 1'b0, 5'h10, 5'h10, 2'h1},
    '{16'h105C, 16'h0810, 16'h0210, 1'b1, 5'h10, 5'h10, 2'h0}};
  always #20 core_clk = ~core_clk;
  charge_pump_current_config u_dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .extOscMode(extOscMode),
    .pumpCfg(pumpCfg), .pumpCurrent(pumpCurrent));
  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regRead <= 1'b1; regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 check(regRdData, e);
  endtask
  // loop current in quarter-microamp units: gain times summed base
  function automatic logic [15:0] cur(input logic [4:0] s, input logic [4:0] k, input logic [1:0] g);
    logic [31:0] b;
    b = (32'(s) + 32'(k)) * 32'd625;
    case (g)
      2'h0: cur = b[15:0];
      2'h1: cur = 16'(2 * b);
      2'h2: cur = 16'(b + b / 2);
      default: cur = 16'(2 * b + b / 2);
    endcase
  endfunction
  task automatic conclude;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      wr(IntPumpOffset, rows[i].r28);
      wr(ExtPumpOffset, rows[i].r29);
      wr(ExtSinkOffset, rows[i].r2a);
      extOscMode <= rows[i].mode;
      repeat (3) @(posedge core_clk);
      #1 check(16'(pumpCfg), {4'h0, rows[i].src, rows[i].snk, rows[i].g});
      check(pumpCurrent, cur(rows[i].src, rows[i].snk, rows[i].g));
      rd(IntPumpOffset, rows[i].r28);
      rd(ExtPumpOffset, rows[i].r29);
    end
    // unmapped write ignored, read gives zero, mapped register untouched
    wr(8'h30, 16'hFFFF);
    rd(8'h30, 16'h0000);
    rd(ExtSinkOffset, 16'h0210);
    // mid-run reset restores the reset contents and configuration
    @(posedge core_clk);
    rstn <= 1'b0;
    extOscMode <= 1'b0;
    #1 check(16'(pumpCfg), 16'h0000);
    check(pumpCurrent, 16'h0000);
    check(regRdData, 16'h0000);
    @(posedge core_clk);
    rstn <= 1'b1;
    rd(IntPumpOffset, 16'h101C);
    rd(ExtPumpOffset, 16'h0810);
    check(16'(pumpCfg), {4'h0, 5'h10, 5'h10, 2'h0});
    check(pumpCurrent, 16'h4E20);
    conclude();
  end
endmodule
`default_nettype wire

// >>> pump_current_pkg.sv
// package: register map, field layout and reset values of the charge-pump current bank
package pump_current_pkg;

  localparam int          AddrWidth          = 8;
  localparam int          DataWidth          = 16;
  localparam int          CodeWidth          = 5;
  localparam int          GainWidth          = 2;
  localparam int          CurWidth           = 16;

  // register offsets
  localparam logic [7:0]  IntPumpOffset      = 8'h28;
  localparam logic [7:0]  ExtPumpOffset      = 8'h29;
  localparam logic [7:0]  ExtSinkOffset      = 8'h2A;

  // reset values
  localparam logic [15:0] IntPumpReset       = 16'h101C;
  localparam logic [15:0] ExtPumpReset       = 16'h0810;
  localparam logic [15:0] ExtSinkReset       = 16'h0210;

  // field positions
  localparam int          ExtSourceLsb       = 7;
  localparam int          ExtGainLsb         = 5;
  localparam int          IntSinkLsb         = 0;
  localparam int          IntSourceLsb       = 8;
  localparam int          IntGainLsb         = 6;
  localparam int          ExtSinkLsb         = 0;

  // one code step in units of 1/4 uA (156.25 uA = 625 quarter-microamps)
  localparam logic [15:0] StepQuarter        = 16'h0271;

  typedef enum logic [1:0] {
    GAIN_1X  = 2'h0,
    GAIN_2X  = 2'h1,
    GAIN_1P5 = 2'h2,
    GAIN_2P5 = 2'h3
  } gain_type;

  typedef struct packed {
    logic [CodeWidth-1:0] sourceCode;
    logic [CodeWidth-1:0] sinkCode;
    gain_type             gain;
  } pump_cfg_type;

endpackage
